// [design/ltb_limit_binning.sv]
`timescale 1ns/10ps
`include "ltb_map.svh"
module ltb_limit_binning #(
  parameter int STROBE_CYC = `LTB_STROBE_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Reading after math processing, scaled value
  input wire logic i_reading_valid,
  input wire logic signed [31:0] i_reading,
  // Limit sets and patterns
  input wire ltb_pkg::ltb_set_t i_set_one,
  input wire ltb_pkg::ltb_set_t i_set_two,
  input wire ltb_pkg::ltb_patterns_t i_patterns,
  // Line control
  input wire logic i_strobe_enable,
  input wire logic [3:0] i_manual_state,
  input wire logic [3:0] i_active_low,
  // Outputs
  output logic [3:0] o_line_level,
  output logic [3:0] o_line_state,
  output logic o_set_one_valid,
  output logic o_set_two_valid,
  output logic o_test_done
);
  import ltb_pkg::*;

  localparam int CW = 12;
  localparam logic [CW-1:0] STROBE_LAST = CW'(STROBE_CYC - 1);

  ltb_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [3:0] state_ln_ff, nxt_state_ln;
  logic [3:0] level_ff, nxt_level;
  logic ctrl_d_ff, strb_d_ff, done_ff, nxt_done;
  logic v1_ff, v2_ff;

  wire ctrl_on = i_set_one.enable | i_set_two.enable;
  wire ctrl_rise = ctrl_on & ~ctrl_d_ff;
  wire strb_rise = i_strobe_enable & ~strb_d_ff;

  // Valid only when high bound exceeds low bound
  wire set1_ok = i_set_one.enable && (i_set_one.high > i_set_one.low);
  wire set2_ok = i_set_two.enable && (i_set_two.high > i_set_two.low);

  // Pattern selection, first failure wins
  function automatic logic [3:0] pick_pattern(input logic signed [31:0] r);
    logic [3:0] p;
    p = i_patterns.pass;
    if (set1_ok && r < i_set_one.low) begin
      p = i_patterns.low_one;
    end else if (set1_ok && r > i_set_one.high) begin
      p = i_patterns.high_one;
    end else if (set2_ok && r < i_set_two.low) begin
      p = i_patterns.low_two;
    end else if (set2_ok && r > i_set_two.high) begin
      p = i_patterns.high_two;
    end
    return p;
  endfunction

  always_comb begin
    logic [3:0] pat;
    pat = pick_pattern(i_reading);
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_state_ln = state_ln_ff;
    nxt_done = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (ctrl_rise) begin
          nxt_state_ln = i_patterns.pass;
          if (i_strobe_enable) begin
            nxt_state_ln[3] = 1'b0;
          end
        end else if (ctrl_on && i_reading_valid) begin
          nxt_state_ln = pat;
          nxt_done = 1'b1;
          if (i_strobe_enable) begin
            // Line four held off so lines one to three settle first
            nxt_state_ln[3] = 1'b0;
            nxt_state = ST_SETUP;
          end
        end else if (!ctrl_on) begin
          nxt_state_ln = i_manual_state;
        end
        if (strb_rise) begin
          nxt_state_ln[3] = 1'b0;
        end
      end
      ST_SETUP: begin
        nxt_state_ln[3] = 1'b1;
        nxt_cnt = '0;
        nxt_state = ST_STROBE;
      end
      ST_STROBE: begin
        nxt_cnt = cnt_ff + CW'(1);
        if (cnt_ff == STROBE_LAST) begin
          nxt_state_ln[3] = 1'b0;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Disabling binning stops the pulse but leaves the line level alone
    if (!i_strobe_enable && state_ff != ST_IDLE) begin
      nxt_state = ST_IDLE;
      nxt_state_ln[3] = state_ln_ff[3];
    end
    nxt_level = nxt_state_ln ^ i_active_low;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      state_ln_ff <= `LTB_OUT_RST;
      level_ff <= `LTB_OUT_RST;
      ctrl_d_ff <= 1'b0;
      strb_d_ff <= 1'b0;
      done_ff <= 1'b0;
      v1_ff <= 1'b0;
      v2_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      state_ln_ff <= nxt_state_ln;
      level_ff <= nxt_level;
      ctrl_d_ff <= ctrl_on;
      strb_d_ff <= i_strobe_enable;
      done_ff <= nxt_done;
      v1_ff <= set1_ok;
      v2_ff <= set2_ok;
    end
  end

  assign o_line_level = level_ff;
  assign o_line_state = state_ln_ff;
  assign o_test_done = done_ff;
  assign o_set_one_valid = v1_ff;
  assign o_set_two_valid = v2_ff;

  // Helper counter of strobe high time
  logic [CW-1:0] hi_cnt_ff;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hi_cnt_ff <= '0;
    end else if (state_ln_ff[3] && i_strobe_enable) begin
      hi_cnt_ff <= hi_cnt_ff + CW'(1);
    end else begin
      hi_cnt_ff <= '0;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  // Reset value of the level ignores polarity, so skip the first edge
  chk_polarity_map: assert property (
    $past(i_reset_n) |->
      o_line_level == (o_line_state ^ $past(i_active_low)))
    else $error("line level does not follow polarity");
  chk_strobe_width: assert property (
    $fell(state_ln_ff[3]) && $past(state_ff) == ST_STROBE
      |-> $past(hi_cnt_ff) >= STROBE_LAST)
    else $error("strobe shorter than minimum");
  chk_strobe_enable_off: assert property (
    $rose(i_strobe_enable) |=> !o_line_state[3])
    else $error("strobe not forced false on enable");
  chk_ctrl_pass: assert property (
    ctrl_rise && !i_strobe_enable |=> o_line_state == $past(i_patterns.pass))
    else $error("pass pattern not applied on control enable");
  chk_first_fail: assert property (
    state_ff == ST_IDLE && !ctrl_rise && ctrl_on && i_reading_valid
      && !i_strobe_enable && set1_ok && i_reading < i_set_one.low
      |=> o_line_state == $past(i_patterns.low_one))
    else $error("low one failure pattern not selected");
  chk_strobe_setup: assert property (
    $rose(o_line_state[3]) && i_strobe_enable
      |-> $stable(o_line_state[2:0]))
    else $error("lines changed with strobe edge");
  chk_manual_block: assert property (
    ctrl_on && !ctrl_rise && !i_reading_valid && state_ff == ST_IDLE
      && !strb_rise |=> $stable(o_line_state))
    else $error("manual write changed controlled lines");
  chk_invalid_set: assert property (
    i_set_one.enable && i_set_one.high <= i_set_one.low |=> !o_set_one_valid)
    else $error("invalid set reported valid");
  chk_invalid_set_two: assert property (
    i_set_two.enable && i_set_two.high <= i_set_two.low
      |=> !o_set_two_valid)
    else $error("invalid second set reported valid");
  chk_valid_set_one: assert property (
    i_set_one.enable && i_set_one.high > i_set_one.low
      |=> o_set_one_valid)
    else $error("valid first set not reported");
  chk_ctrl_pass_bin: assert property (
    ctrl_rise && i_strobe_enable
      |=> o_line_state == {1'b0, $past(i_patterns.pass[2:0])})
    else $error("pass pattern with strobe off not applied");
  chk_line_four_bin: assert property (
    state_ff == ST_IDLE && ctrl_on && !ctrl_rise && i_reading_valid
      && i_strobe_enable |=> !o_line_state[3])
    else $error("pattern drove line four while binning");
  chk_disable_hold: assert property (
    !i_strobe_enable && state_ff != ST_IDLE
      |=> o_line_state[3] == $past(o_line_state[3]))
    else $error("strobe line moved when binning disabled");
  chk_manual_follow: assert property (
    !ctrl_on && state_ff == ST_IDLE && !strb_rise
      |=> o_line_state == $past(i_manual_state))
    else $error("manual state not applied while uncontrolled");
  chk_test_done: assert property (
    state_ff == ST_IDLE && ctrl_on && !ctrl_rise && i_reading_valid
      |=> o_test_done)
    else $error("tested reading not flagged done");

  cov_strobe: cover property (state_ff == ST_STROBE ##1 state_ff == ST_IDLE);
  cov_pass: cover property (o_test_done && o_line_state == $past(i_patterns.pass, 1));
  cov_manual: cover property (!ctrl_on ##1 ctrl_on);
  cov_strobe_abort: cover property (state_ff == ST_STROBE && !i_strobe_enable);
endmodule

// [design/ltb_map.svh]
// Summary of operation
// - Two limit sets each hold a low and high bound, and each set can be enabled or not.
// - Comparison uses the fully scaled, post-math reading value.
// - Tests run in order low one, high one, low two, high two; the first failure selects its pattern.
// - When every enabled test passes the all-pass pattern is driven.
// - Only an enabled set may change the output lines.
// - A set is valid only when high exceeds low; bounds are taken unchecked.
// - Patterns are logical on/off values; polarity is applied last.
// - With binning on, line four pulses true for more than 10 us after each completed test.
// - Enabling binning forces the strobe false; disabling leaves it as is.
// - While binning is on, line four ignores pass and failure patterns.
// - Enabling output control while no strobe pulse runs drives the pass pattern at once, strobe off when binning.
// - Each line has its own polarity; active low drives logical on as low level.
// - While any set controls the lines, manual writes do not change them.
`ifndef LTB_MAP_SVH
`define LTB_MAP_SVH
`define LTB_CLK_MHZ 125
`define LTB_STROBE_NS 10000
// More than 10 us: one cycle beyond the exact figure
`define LTB_STROBE_CYC ((`LTB_STROBE_NS * `LTB_CLK_MHZ) / 1000 + 1)
`define LTB_LINES 4
`define LTB_DATA_W 32
`define LTB_OUT_RST 4'h0
`endif

// [design/ltb_pkg.sv]
package ltb_pkg;
  typedef struct packed {
    logic signed [31:0] low;
    logic signed [31:0] high;
    logic enable;
  } ltb_set_t;
  typedef struct packed {
    logic [3:0] low_one;
    logic [3:0] high_one;
    logic [3:0] low_two;
    logic [3:0] high_two;
    logic [3:0] pass;
  } ltb_patterns_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b100
  } ltb_state_t;
endpackage

// [verif/ltb_handler.sv]
`timescale 1ns/10ps
module ltb_handler (
  input wire logic i_mclk,
  input wire logic [3:0] i_level,
  input wire logic [3:0] i_active_low,
  output logic [2:0] o_bin,
  output int o_width
);
  logic [3:0] on;
  logic strobe_q = 1'b0;
  int cnt = 0;
  // Handler sees pins, so undo the polarity first
  assign on = i_level ^ i_active_low;
  always @(posedge i_mclk) begin
    strobe_q <= on[3];
    if (on[3] && !strobe_q) begin
      o_bin <= on[2:0];
      cnt <= 1;
    end else if (on[3]) begin
      cnt <= cnt + 1;
    end
    if (!on[3] && strobe_q) begin
      o_width <= cnt;
    end
  end
endmodule

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import ltb_pkg::*;
  localparam int SC = 8;
  logic clk = 0, rst_n = 0, vld = 0, sen = 0;
  logic signed [31:0] rdg = 0;
  ltb_set_t s1, s2;
  ltb_patterns_t pat;
  logic [3:0] man = 0, alow = 4'h3, lvl, st;
  logic v1, v2, done;
  logic [2:0] bin;
  int width, mismatches = 0, cmp_count = 0;
  ltb_limit_binning #(.STROBE_CYC(SC)) i_dut (.i_mclk(clk),
    .i_reset_n(rst_n), .i_reading_valid(vld), .i_reading(rdg),
    .i_set_one(s1), .i_set_two(s2), .i_patterns(pat),
    .i_strobe_enable(sen), .i_manual_state(man), .i_active_low(alow),
    .o_line_level(lvl), .o_line_state(st), .o_set_one_valid(v1),
    .o_set_two_valid(v2), .o_test_done(done));
  ltb_handler i_hdl (.i_mclk(clk), .i_level(lvl), .i_active_low(alow),
    .o_bin(bin), .o_width(width));
  initial forever #4 clk = ~clk;
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Gap between readings stays above SC+3 cycles, so none is dropped
  task automatic measure(logic [31:0] v, logic [3:0] e);
    int i;
    @(posedge clk);
    vld <= 1;
    rdg <= v;
    @(posedge clk);
    vld <= 0;
    for (i = 0; i < 4 && done !== 1'b1; i++) @(negedge clk);
    check("done", done, 1);
    check("state", st, e);
    check("level", lvl, e ^ alow);
    if (sen) begin
      repeat (SC + 4) @(posedge clk);
      check("bin", bin, e[2:0]);
      check("width", width, SC);
    end
  endtask
  initial begin
    s1 = '{low: 32'h0001_5F90, high: 32'h0001_ADB0, enable: 0};
    s2 = '{low: 32'h0001_82B8, high: 32'h0001_8A88, enable: 0};
    pat = '{low_one: 4'h1, high_one: 4'h2, low_two: 4'h3,
      high_two: 4'hC, pass: 4'h8};
    repeat (20) @(posedge clk);
    rst_n <= 1;
    man <= 4'h5;
    repeat (3) @(negedge clk);
    check("manual", st, 4'h5);
    @(posedge clk);
    sen <= 1;
    s1.enable <= 1;
    s2.enable <= 1;
    man <= 4'hA;
    repeat (3) @(negedge clk);
    check("arm", st, 4'h0);
    check("valid", {v1, v2}, 2'b11);
    measure(32'h0001_3880, 4'h1);
    measure(32'h0001_D4C0, 4'h2);
    measure(32'h0001_7318, 4'h3);
    measure(32'h0001_9A28, 4'h4);
    measure(32'h0001_86A0, 4'h0);
    measure(32'h0001_5F90, 4'h3);
    measure(32'hFFFF_FFFB, 4'h1);
    s2.high <= 32'h0001_82B8;
    measure(32'h0001_7318, 4'h0);
    check("valid", {v1, v2}, 2'b10);
    s2.high <= 32'h0001_8A88;
    s1.enable <= 0;
    measure(32'h0001_3880, 4'h3);
    @(posedge clk);
    vld <= 1;
    rdg <= 32'h0001_3880;
    @(posedge clk);
    vld <= 0;
    repeat (3) @(posedge clk);
    sen <= 0;
    repeat (2) @(negedge clk);
    check("hold", st[3], 1);
    measure(32'h0001_86A0, 4'h8);
    @(posedge clk);
    sen <= 1;
    repeat (2) @(negedge clk);
    check("strobe", st[3], 0);
    @(posedge clk);
    sen <= 0;
    s2.enable <= 0;
    @(posedge clk);
    @(posedge clk);
    s1.enable <= 1;
    @(negedge clk);
    check("manual", st, 4'hA);
    @(negedge clk);
    check("pass", st, 4'h8);
    measure(32'h0001_3880, 4'h1);
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
endmodule
